/* File: logic/cam_seq.sv */
`timescale 1ns/100ps
`default_nettype none

module cam_seq (
  input wire logic clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave.
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // Camera side.
  input wire logic host_link_i,
  input wire logic trigger_i,
  input wire logic [1:0] gpio_i,
  output logic flash_o,
  output logic expose_o,
  output logic frame_done_o
);
  import cam_seq_pkg::*;

  // ****************************************************************
  // Registers and state.
  // ****************************************************************
  logic [5:0] ctrl_r;
  logic [31:0] trig_delay_r;
  logic [31:0] exposure_r;
  logic [31:0] flash_delay_r;
  logic [31:0] flash_dur_r;
  logic [31:0] latency_r;
  logic [31:0] readout_r;
  cap_param_type shadow_r;
  cap_param_type active_r;
  seq_state_type state_r;
  logic [31:0] cnt_r;
  logic [15:0] frame_cnt_r;
  logic [31:0] delay_total;
  logic trig_level;
  logic trig_edge;
  logic start;
  logic frame_start;
  logic expose_start;
  logic expose_end;
  logic link_lost;

  // AXI bookkeeping.
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_write;
  logic [31:0] ctrl_wr;

  // Byte-lane merge used by every writable word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // Address decode shared by read and write paths.
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_READOUT);
  endfunction : mapped

  // ****************************************************************
  // AXI4-Lite write channel.
  // ****************************************************************
  assign s_awready_o = !aw_held_r && !bvalid_r;
  assign s_wready_o = !w_held_r && !bvalid_r;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign s_bvalid_o = bvalid_r;
  assign s_bresp_o = bresp_r;

  // Address and data are caught in either order; the response follows both.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= ZERO_WORD;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_held_r <= 1'b1;
        wdata_r <= s_wdata_i;
        wstrb_r <= s_wstrb_i;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (mapped(awaddr_r) && awaddr_r != ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_bready_i) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // The control word is merged at full width first; only its low six bits are kept.
  assign ctrl_wr = merge({26'h0, ctrl_r}, wdata_r, wstrb_r);

  // Register writes; a lost host link drops the output setup to defaults.
  always_ff @(posedge clk_i) begin
    if (rst_i || link_lost) begin
      ctrl_r <= CTRL_RESET;
      trig_delay_r <= ZERO_WORD;
      exposure_r <= EXPOSURE_RESET;
      flash_delay_r <= ZERO_WORD;
      flash_dur_r <= ZERO_WORD;
      latency_r <= LATENCY_RESET;
      readout_r <= READOUT_RESET;
    end else if (do_write) begin
      unique case (awaddr_r)
        ADDR_CTRL: ctrl_r <= ctrl_wr[5:0];
        ADDR_TRIG_DELAY: trig_delay_r <= merge(trig_delay_r, wdata_r, wstrb_r);
        ADDR_EXPOSURE: exposure_r <= merge(exposure_r, wdata_r, wstrb_r);
        ADDR_FLASH_DELAY: flash_delay_r <= merge(flash_delay_r, wdata_r, wstrb_r);
        ADDR_FLASH_DUR: flash_dur_r <= merge(flash_dur_r, wdata_r, wstrb_r);
        ADDR_LATENCY: latency_r <= merge(latency_r, wdata_r, wstrb_r);
        ADDR_READOUT: readout_r <= merge(readout_r, wdata_r, wstrb_r);
        default: ;
      endcase
    end
  end

  assign link_lost = !host_link_i;

  // ****************************************************************
  // AXI4-Lite read channel.
  // ****************************************************************
  assign s_arready_o = !rvalid_r;
  assign s_rvalid_o = rvalid_r;
  assign s_rdata_o = rdata_r;
  assign s_rresp_o = rresp_r;

  // Status shows the live input levels and the sequencer's progress.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= ZERO_WORD;
      rresp_r <= RESP_OKAY;
    end else if (s_arvalid_i && s_arready_o) begin
      rvalid_r <= 1'b1;
      rresp_r <= mapped(s_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_araddr_i)
        ADDR_CTRL: rdata_r <= {26'h0, ctrl_r};
        ADDR_TRIG_DELAY: rdata_r <= trig_delay_r;
        ADDR_EXPOSURE: rdata_r <= exposure_r;
        ADDR_FLASH_DELAY: rdata_r <= flash_delay_r;
        ADDR_FLASH_DUR: rdata_r <= flash_dur_r;
        ADDR_STATUS: rdata_r <= {frame_cnt_r, 8'h00, 1'b0, state_r, gpio_i, flash_o,
                                 trig_level};
        ADDR_LATENCY: rdata_r <= latency_r;
        ADDR_READOUT: rdata_r <= readout_r;
        default: rdata_r <= ZERO_WORD;
      endcase
    end else if (rvalid_r && s_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Capture sequencer.
  // ****************************************************************
  // The general-purpose inputs are deliberately not wired to the edge detector.
  edge_pick u_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sig_i(trigger_i),
    .falling_i(ctrl_r[CTRL_FALLING]),
    .level_o(trig_level),
    .edge_o(trig_edge)
  );

  // Trigger mode waits for an edge in idle; freerun starts at once.
  assign start = (state_r == ST_IDLE) && ctrl_r[CTRL_RUN] &&
                 (ctrl_r[CTRL_TRIG_MODE] ? trig_edge : 1'b1);
  assign frame_start = start;

  // Freerun snapshots registers at each readout start, so a write landing
  // mid-frame reaches the sensor in the next frame, or in the one after it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shadow_r <= '0;
    end else if (state_r == ST_EXPOSE && cnt_r == 32'h0000_0001) begin
      shadow_r <= {trig_delay_r, exposure_r, flash_delay_r, flash_dur_r, latency_r,
                   readout_r, ctrl_r[CTRL_ROLLING]};
    end
  end

  // Trigger mode latches live registers at the edge: idle writes apply next.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_r <= '0;
    end else if (start) begin
      if (ctrl_r[CTRL_TRIG_MODE] || frame_cnt_r == 16'h0000) begin
        active_r <= {trig_delay_r, exposure_r, flash_delay_r, flash_dur_r, latency_r,
                     readout_r, ctrl_r[CTRL_ROLLING]};
      end else begin
        active_r <= shadow_r;
      end
    end
  end

  assign delay_total = INT_TRIG_DELAY + (ctrl_r[CTRL_TRIG_MODE] ? trig_delay_r : ZERO_WORD);

  // Edges during busy states are dropped since start needs idle.
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_r[CTRL_RUN]) begin
      state_r <= ST_IDLE;
      cnt_r <= ZERO_WORD;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_DELAY;
            cnt_r <= delay_total;
          end
        end
        ST_DELAY: begin
          if (cnt_r <= 32'h0000_0001) begin
            state_r <= ST_LATENCY;
            cnt_r <= active_r.latency;
          end else begin
            cnt_r <= cnt_r - 32'h0000_0001;
          end
        end
        ST_LATENCY: begin
          if (cnt_r <= 32'h0000_0001) begin
            state_r <= ST_EXPOSE;
            cnt_r <= active_r.exposure;
          end else begin
            cnt_r <= cnt_r - 32'h0000_0001;
          end
        end
        ST_EXPOSE: begin
          if (cnt_r <= 32'h0000_0001) begin
            state_r <= ST_READOUT;
            cnt_r <= active_r.readout;
          end else begin
            cnt_r <= cnt_r - 32'h0000_0001;
          end
        end
        ST_READOUT: begin
          if (cnt_r <= 32'h0000_0001) begin
            state_r <= ST_IDLE;
            cnt_r <= ZERO_WORD;
          end else begin
            cnt_r <= cnt_r - 32'h0000_0001;
          end
        end
      endcase
    end
  end

  assign expose_start = (state_r == ST_LATENCY) && (cnt_r <= 32'h0000_0001);
  assign expose_end = (state_r == ST_EXPOSE) && (cnt_r <= 32'h0000_0001);

  // Frame counter and hand-off pulse toward the transfer path.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_cnt_r <= 16'h0000;
      frame_done_o <= 1'b0;
      expose_o <= 1'b0;
    end else begin
      frame_done_o <= (state_r == ST_READOUT) && (cnt_r <= 32'h0000_0001);
      expose_o <= (state_r == ST_LATENCY && cnt_r <= 32'h0000_0001) ||
                  (state_r == ST_EXPOSE && cnt_r > 32'h0000_0001);
      if (frame_done_o) begin
        frame_cnt_r <= frame_cnt_r + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Flash output, shared by freerun and trigger modes.
  // ****************************************************************
  flash_gen u_flash (
    .clk_i(clk_i),
    .rst_i(rst_i || link_lost),
    .frame_start_i(frame_start),
    .expose_start_i(expose_start),
    .expose_end_i(expose_end),
    .static_i(ctrl_r[CTRL_FLASH_STATIC]),
    .static_level_i(ctrl_r[CTRL_STATIC_LEVEL]),
    .delay_i(active_r.flash_delay),
    .dur_i(active_r.flash_dur),
    .tail_i(active_r.rolling ? AUTO_TAIL_ROLLING : AUTO_TAIL_GLOBAL),
    .flash_o(flash_o)
  );
endmodule : cam_seq

`default_nettype wire

/* File: logic/cam_seq_pkg.sv */
package cam_seq_pkg;

  // ****************************************************************
  // Register map, byte addresses on the AXI4-Lite slave.
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIG_DELAY = 8'h04;
  localparam logic [7:0] ADDR_EXPOSURE = 8'h08;
  localparam logic [7:0] ADDR_FLASH_DELAY = 8'h0c;
  localparam logic [7:0] ADDR_FLASH_DUR = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_LATENCY = 8'h18;
  localparam logic [7:0] ADDR_READOUT = 8'h1c;

  // ****************************************************************
  // Control register fields.
  // ****************************************************************
  localparam int CTRL_TRIG_MODE = 0;
  localparam int CTRL_FALLING = 1;
  localparam int CTRL_FLASH_STATIC = 2;
  localparam int CTRL_STATIC_LEVEL = 3;
  localparam int CTRL_ROLLING = 4;
  localparam int CTRL_RUN = 5;

  // ****************************************************************
  // Reset values and fixed timing.
  // ****************************************************************
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [31:0] EXPOSURE_RESET = 32'h0000_0064;
  localparam logic [31:0] LATENCY_RESET = 32'h0000_0010;
  localparam logic [31:0] READOUT_RESET = 32'h0000_0040;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // Fixed internal trigger delay in cycles.
  localparam logic [31:0] INT_TRIG_DELAY = 32'h0000_0004;
  // Extra cycles the automatic flash stays on after exposure.
  localparam logic [31:0] AUTO_TAIL_GLOBAL = 32'h0000_0002;
  localparam logic [31:0] AUTO_TAIL_ROLLING = 32'h0000_0008;

  // ****************************************************************
  // AXI responses and carrier types.
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELAY,
    ST_LATENCY,
    ST_EXPOSE,
    ST_READOUT
  } seq_state_type;

  // Capture parameters latched at the start of each frame.
  typedef struct packed {
    logic [31:0] trig_delay;
    logic [31:0] exposure;
    logic [31:0] flash_delay;
    logic [31:0] flash_dur;
    logic [31:0] latency;
    logic [31:0] readout;
    logic rolling;
  } cap_param_type;

endpackage : cam_seq_pkg

/* File: logic/edge_pick.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Edge detector on the isolated trigger input, with selectable edge.
// ****************************************************************
module edge_pick (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sig_i,
  input wire logic falling_i,
  output logic level_o,
  output logic edge_o
);
  import cam_seq_pkg::*;

  logic prev_r;

  // The previous level is kept so that both edges can be seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= sig_i;
    end
  end

  assign level_o = prev_r;
  // Only the configured polarity counts as a trigger.
  assign edge_o = falling_i ? (prev_r & ~sig_i) : (~prev_r & sig_i);
endmodule : edge_pick

`default_nettype wire

/* File: logic/flash_gen.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Flash pulse generator: static, automatic or manual timing.
// ****************************************************************
module flash_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic frame_start_i,
  input wire logic expose_start_i,
  input wire logic expose_end_i,
  input wire logic static_i,
  input wire logic static_level_i,
  input wire logic [31:0] delay_i,
  input wire logic [31:0] dur_i,
  input wire logic [31:0] tail_i,
  output logic flash_o
);
  import cam_seq_pkg::*;

  logic on_r;
  logic wait_r;
  logic [31:0] cnt_r;
  logic manual;

  assign manual = (delay_i != ZERO_WORD) || (dur_i != ZERO_WORD);

  // One counter serves the delay, the duration and the automatic tail.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_r <= 1'b0;
      wait_r <= 1'b0;
      cnt_r <= ZERO_WORD;
    end else if (frame_start_i) begin
      on_r <= 1'b0;
      wait_r <= 1'b0;
      cnt_r <= ZERO_WORD;
    end else if (expose_start_i) begin
      // Delay counts from true exposure start, after sensor latency.
      if (manual && delay_i != ZERO_WORD) begin
        wait_r <= 1'b1;
        cnt_r <= delay_i;
      end else begin
        on_r <= 1'b1;
        cnt_r <= manual ? dur_i : ZERO_WORD;
      end
    end else if (wait_r) begin
      if (cnt_r == 32'h0000_0001) begin
        wait_r <= 1'b0;
        on_r <= (dur_i != ZERO_WORD);
        cnt_r <= dur_i;
      end else begin
        cnt_r <= cnt_r - 32'h0000_0001;
      end
    end else if (on_r) begin
      if (!manual && expose_end_i) begin
        cnt_r <= tail_i;
      end else if (cnt_r == 32'h0000_0001) begin
        on_r <= 1'b0;
        cnt_r <= ZERO_WORD;
      end else if (cnt_r != ZERO_WORD) begin
        cnt_r <= cnt_r - 32'h0000_0001;
      end
    end
  end

  // Static mode overrides the timed pulse.
  assign flash_o = static_i ? static_level_i : on_r;
endmodule : flash_gen

`default_nettype wire

/* File: verif/cam_seq_properties.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Port checker for the capture sequencer.
// ****************************************************************
module cam_seq_properties
  import cam_seq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic s_awvalid_i,
  input wire logic s_awready_o,
  input wire logic s_wvalid_i,
  input wire logic s_wready_o,
  input wire logic [1:0] s_bresp_o,
  input wire logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  input wire logic s_arready_o,
  input wire logic [31:0] s_rdata_o,
  input wire logic [1:0] s_rresp_o,
  input wire logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire logic expose_o,
  input wire logic frame_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Both halves of a write taken together, and a read address taken.
  sequence wr_take;
    s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o;
  endsequence
  sequence rd_take;
    s_arvalid_i && s_arready_o;
  endsequence

  done_pulse_a: assert property (frame_done_o |=> !frame_done_o)
    else $error("frame done wider than one cycle");
  write_answer_a: assert property (wr_take |-> ##2 s_bvalid_o)
    else $error("write response late");
  read_answer_a: assert property (rd_take |=> s_rvalid_o)
    else $error("read data late");
  bresp_hold_a: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
    else $error("read data dropped early");
  bad_read_a: assert property (s_arvalid_i && s_arready_o && s_araddr_i > ADDR_READOUT
    |=> s_rresp_o == RESP_SLVERR && s_rdata_o == ZERO_WORD)
    else $error("unmapped read not refused");
  done_idle_a: assert property (frame_done_o |-> !expose_o)
    else $error("frame done during exposure");
  readout_end_a: assert property ($fell(expose_o) |-> ##[1:1000] frame_done_o)
    else $error("no frame done after exposure");
endmodule : cam_seq_properties

`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import cam_seq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rd_data;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic host_link = 1'b1;
  logic [1:0] gpio = 2'h0, bresp, rresp;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, trigger, flash, expose, done;
  int bad_count = 0, checked = 0, last_len, n;

  always #50 clk_i = ~clk_i;

  cam_seq dut_u (.clk_i(clk_i), .rst_i(rst_i), .s_awaddr_i(awaddr), .s_awvalid_i(awvalid),
    .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid),
    .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
    .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready), .s_rdata_o(rd_data),
    .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready), .host_link_i(host_link),
    .trigger_i(trigger), .gpio_i(gpio), .flash_o(flash), .expose_o(expose), .frame_done_o(done));

  trig_src_model model_u (.clk_i(clk_i), .flash_i(flash), .trigger_o(trigger),
    .last_len_o(last_len));

  // ****************************************************************
  // Bus and compare tasks.
  // ****************************************************************
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Ready is raised only once the answer shows, so a held answer is exercised too.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
    end while (bvalid !== 1'b1 || bready !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  // Read data is taken at the edge where rvalid and rready are both high.
  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
    end while (rvalid !== 1'b1 || rready !== 1'b1);
    rready <= 1'b0;
    chk(what, ed, rd_data);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd_chk

  task count_done(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge clk_i);
      if (done === 1'b1) n++;
    end
  endtask : count_done

  // Rising trigger, then exposure length, flash offset from exposure start and flash length.
  task frame_test(input logic [31:0] ctrl, fdel, fdur, e_exp, e_off, e_len);
    int t, elen, foff;
    wr(ADDR_FLASH_DELAY, fdel, RESP_OKAY);
    wr(ADDR_FLASH_DUR, fdur, RESP_OKAY);
    wr(ADDR_CTRL, ctrl, RESP_OKAY);
    model_u.step(1'b0);
    model_u.step(1'b1);
    elen = 0;
    foff = -1;
    t = 0;
    while (expose !== 1'b1 && t < 300) begin
      @(posedge clk_i);
      t++;
    end
    t = 0;
    while (done !== 1'b1 && t < 400) begin
      if (expose === 1'b1) elen++;
      if (flash === 1'b1 && foff < 0) foff = t;
      @(posedge clk_i);
      t++;
    end
    chk("expose len", e_exp, elen);
    chk("flash offset", e_off, foff);
    chk("flash len", e_len, last_len);
    $display("test frame ctrl %h done", ctrl);
  endtask : frame_test

  task print_verdict();
    $display("counts checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("ctrl", ADDR_CTRL, ZERO_WORD, RESP_OKAY);
    rd_chk("exposure", ADDR_EXPOSURE, EXPOSURE_RESET, RESP_OKAY);
    rd_chk("latency", ADDR_LATENCY, LATENCY_RESET, RESP_OKAY);
    rd_chk("readout", ADDR_READOUT, READOUT_RESET, RESP_OKAY);
    rd_chk("unmapped", 8'h20, ZERO_WORD, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h0000_0001, RESP_SLVERR);
    wr(ADDR_TRIG_DELAY, 32'h0000_0002, RESP_OKAY);
    wr(ADDR_EXPOSURE, 32'h0000_000a, RESP_OKAY);
    wr(ADDR_LATENCY, 32'h0000_0003, RESP_OKAY);
    wr(ADDR_READOUT, 32'h0000_0014, RESP_OKAY);
    rd_chk("trig delay", ADDR_TRIG_DELAY, 32'h0000_0002, RESP_OKAY);
    $display("test registers done");
    frame_test(32'h21, 0, 0, 10, 0, 32'ha + AUTO_TAIL_GLOBAL);
    frame_test(32'h21, 3, 5, 10, 3, 5);
    wr(ADDR_EXPOSURE, 32'h0000_0006, RESP_OKAY);
    frame_test(32'h31, 0, 0, 6, 0, 32'h6 + AUTO_TAIL_ROLLING);
    // Falling edge mode: a falling edge gives one frame; a later rising edge and gpio changes must not add a frame.
    wr(ADDR_CTRL, 32'h0000_0023, RESP_OKAY);
    model_u.step(1'b0);
    model_u.step(1'b1);
    model_u.step(1'b0);
    count_done(150);
    chk("frames on falling", 1, n);
    model_u.step(1'b1);
    count_done(100);
    chk("frames on rising", 0, n);
    gpio <= 2'b11;
    repeat (3) @(posedge clk_i);
    gpio <= 2'b10;
    count_done(100);
    chk("frames from gpio", 0, n);
    rd_chk("status", ADDR_STATUS, 32'h0004_0009, RESP_OKAY);
    $display("test edges done");
    wr(ADDR_CTRL, 32'h0000_000c, RESP_OKAY);
    @(posedge clk_i);
    chk("static high", 1, flash);
    wr(ADDR_CTRL, 32'h0000_0004, RESP_OKAY);
    @(posedge clk_i);
    chk("static low", 0, flash);
    wr(ADDR_CTRL, 32'h0000_0020, RESP_OKAY);
    count_done(300);
    chk("freerun frames", 1, n > 0);
    chk("freerun flash len", 32'h6 + AUTO_TAIL_GLOBAL, last_len);
    // Stop freerun just after a frame ends, so no exposure is cut short.
    while (done !== 1'b1) @(posedge clk_i);
    wr(ADDR_CTRL, 32'h0000_000c, RESP_OKAY);
    host_link <= 1'b0;
    repeat (2) @(posedge clk_i);
    host_link <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("flash after link loss", 0, flash);
    rd_chk("ctrl after link loss", ADDR_CTRL, ZERO_WORD, RESP_OKAY);
    wstrb <= 4'h2;
    wr(ADDR_FLASH_DELAY, 32'h1234_5678, RESP_OKAY);
    wstrb <= 4'hf;
    rd_chk("byte lane", ADDR_FLASH_DELAY, 32'h0000_5600, RESP_OKAY);
    $display("test modes done");
    print_verdict();
  end

  // A hang costs a mismatch and ends the run the normal way.
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end
endmodule : tb_top

bind cam_seq cam_seq_properties chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .s_awvalid_i(s_awvalid_i), .s_awready_o(s_awready_o), .s_wvalid_i(s_wvalid_i),
  .s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o), .s_bvalid_o(s_bvalid_o),
  .s_bready_i(s_bready_i), .s_araddr_i(s_araddr_i), .s_arvalid_i(s_arvalid_i),
  .s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o),
  .s_rvalid_o(s_rvalid_o), .s_rready_i(s_rready_i), .expose_o(expose_o),
  .frame_done_o(frame_done_o));

`default_nettype wire

/* File: verif/trig_src_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Trigger source and flash lamp on the far side.
// ****************************************************************
module trig_src_model (
  input wire logic clk_i,
  input wire logic flash_i,
  output logic trigger_o,
  output int last_len_o
);
  int run_len = 0;

  initial trigger_o = 1'b0;
  initial last_len_o = 0;

  // The lamp records the length of each finished pulse, so a stuck output shows as no pulse.
  always @(posedge clk_i) begin
    if (flash_i === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_len_o <= run_len;
      run_len <= 0;
    end
  end

  // One level change, held long enough for the edge detector to see it.
  task step(input logic lvl);
    trigger_o <= lvl;
    repeat (3) @(posedge clk_i);
  endtask : step
endmodule : trig_src_model

`default_nettype wire
